// file: common/ccis_pkg.sv
// Shared constants of the card coupler alert and select block
package ccis_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] EVENT_OFS  = 8'h04;
    localparam logic [7:0] MASK_OFS   = 8'h08;
    localparam logic [7:0] STATE_OFS  = 8'h0C;

    // ****************************************
    // Control fields
    // ****************************************
    localparam int CTRL_CLK_RUN  = 0;
    localparam int CTRL_STOP_LVL = 1;
    localparam int CTRL_IDLE_EN  = 2;
    localparam int CTRL_W        = 3;
    localparam logic [2:0] CTRL_RST = 3'h1;

    // ****************************************
    // Event and mask fields (same layout)
    // ****************************************
    localparam int EV_CARD     = 0;
    localparam int EV_OVERLOAD = 1;
    localparam int EV_SUPPLY   = 2;
    localparam int EV_BATTERY  = 3;
    localparam int EV_W        = 4;
    localparam logic [3:0] EVENT_RST = 4'h0;
    localparam logic [3:0] MASK_RST  = 4'h0;

    // ****************************************
    // Live state fields
    // ****************************************
    localparam int ST_CARD    = 0;
    localparam int ST_SUPPLY  = 1;
    localparam int ST_IDLE    = 2;
    localparam int ST_SEL     = 3;
    localparam int ST_SFAULT  = 4;
    localparam int ST_BFAULT  = 5;
    localparam int ST_ALERT   = 6;
    localparam int ST_W       = 7;

    // ****************************************
    // Synchronised pin bundle positions
    // ****************************************
    localparam int PIN_SEL_N  = 0;
    localparam int PIN_SUP_EN = 1;
    localparam int PIN_DET    = 2;
    localparam int PIN_OVLD   = 3;
    localparam int PIN_S_OV   = 4;
    localparam int PIN_S_UV   = 5;
    localparam int PIN_B_OV   = 6;
    localparam int PIN_B_UV   = 7;
    localparam int PIN_DATA   = 8;
    localparam int PIN_RST    = 9;
    localparam int PIN_W      = 10;

    // ****************************************
    // Card clock divider default
    // ****************************************
    localparam int CLK_DIV_DEF = 2;

    typedef enum logic [2:0] {
        PW_OFF  = 3'b001,
        PW_ON   = 3'b010,
        PW_IDLE = 3'b100
    } ccis_pw_t;

endpackage

// file: hw/ccis_sync.sv
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module ccis_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] dout_d;

    always_comb begin
        meta_d = din;
        dout_d = meta_q;
    end

    // Inputs settle at zero, a card-deselected state is set in the caller
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= meta_d;
            dout   <= dout_d;
        end
    end

endmodule

// file: hw/ccis_top.sv
// Alert, status feedback and select control of a card coupler
`timescale 1ns/100ps

module ccis_top #(
    parameter int CLK_DIV = ccis_pkg::CLK_DIV_DEF
) (
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Host side pins
    input  wire logic        unit_select_n,
    input  wire logic        supply_enable,
    input  wire logic        host_data_in,
    input  wire logic        host_reset_n,
    output logic             host_alert_n,
    output logic             status_out,
    // Card side pins and analog monitors
    input  wire logic        card_detect_input,
    input  wire logic        supply_overload,
    input  wire logic        supply_over_v,
    input  wire logic        supply_under_v,
    input  wire logic        battery_over_v,
    input  wire logic        battery_under_v,
    output logic             card_supply,
    output logic             card_clock_out,
    output logic             card_data_line,
    output logic             card_reset_line,
    output logic             host_inputs_active,
    output logic             low_power_idle,
    output logic             irq
);

    // ****************************************
    // Pin synchronisation
    // ****************************************
    logic [ccis_pkg::PIN_W-1:0] pin_raw;
    logic [ccis_pkg::PIN_W-1:0] pin_s;

    always_comb begin
        pin_raw = '0;
        pin_raw[ccis_pkg::PIN_SEL_N]  = ~unit_select_n;
        pin_raw[ccis_pkg::PIN_SUP_EN] = supply_enable;
        pin_raw[ccis_pkg::PIN_DET]    = card_detect_input;
        pin_raw[ccis_pkg::PIN_OVLD]   = supply_overload;
        pin_raw[ccis_pkg::PIN_S_OV]   = supply_over_v;
        pin_raw[ccis_pkg::PIN_S_UV]   = supply_under_v;
        pin_raw[ccis_pkg::PIN_B_OV]   = battery_over_v;
        pin_raw[ccis_pkg::PIN_B_UV]   = battery_under_v;
        pin_raw[ccis_pkg::PIN_DATA]   = host_data_in;
        pin_raw[ccis_pkg::PIN_RST]    = ~host_reset_n;
    end

    // Select and reset are inverted so that a reset value of zero means idle
    ccis_sync #(
        .W (ccis_pkg::PIN_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (pin_raw),
        .dout    (pin_s)
    );

    logic sel;
    logic sup_en;
    logic det;
    logic ovld;
    logic sfault;
    logic bfault;

    always_comb begin
        sel    = pin_s[ccis_pkg::PIN_SEL_N];
        sup_en = pin_s[ccis_pkg::PIN_SUP_EN];
        det    = pin_s[ccis_pkg::PIN_DET];
        ovld   = pin_s[ccis_pkg::PIN_OVLD];
        sfault = pin_s[ccis_pkg::PIN_S_OV] | pin_s[ccis_pkg::PIN_S_UV];
        bfault = pin_s[ccis_pkg::PIN_B_OV] | pin_s[ccis_pkg::PIN_B_UV];
    end

    // ****************************************
    // Edge history
    // ****************************************
    logic sel_q;
    logic sel_d;
    logic sup_en_q;
    logic sup_en_d;
    logic det_q;
    logic det_d;
    logic ovld_q;
    logic ovld_d;
    logic sfault_q;
    logic sfault_d;
    logic bfault_q;
    logic bfault_d;

    always_comb begin
        sel_d    = sel;
        sup_en_d = sup_en;
        det_d    = det;
        ovld_d   = ovld;
        sfault_d = sfault;
        bfault_d = bfault;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q    <= 1'b0;
            sup_en_q <= 1'b0;
            det_q    <= 1'b0;
            ovld_q   <= 1'b0;
            sfault_q <= 1'b0;
            bfault_q <= 1'b0;
        end else begin
            sel_q    <= sel_d;
            sup_en_q <= sup_en_d;
            det_q    <= det_d;
            ovld_q   <= ovld_d;
            sfault_q <= sfault_d;
            bfault_q <= bfault_d;
        end
    end

    logic card_evt;
    logic ovld_evt;
    logic alert_clr;
    logic sup_rise;

    always_comb begin
        card_evt  = det ^ det_q;
        ovld_evt  = ovld & ~ovld_q;
        // Enable edges only count while selected
        sup_rise  = sel & sup_en & ~sup_en_q;
        alert_clr = (sel_q & ~sel) | sup_rise;
    end

    // ****************************************
    // Power state
    // ****************************************
    ccis_pkg::ccis_pw_t pw_q;
    ccis_pkg::ccis_pw_t pw_d;
    logic [ccis_pkg::CTRL_W-1:0] ctrl_q;

    always_comb begin
        pw_d = pw_q;
        unique case (pw_q)
            ccis_pkg::PW_OFF: begin
                if (sup_rise && !bfault) begin
                    pw_d = ccis_pkg::PW_ON;
                end else if (!sel && ctrl_q[ccis_pkg::CTRL_IDLE_EN] && !det) begin
                    pw_d = ccis_pkg::PW_IDLE;
                end
            end
            ccis_pkg::PW_ON: begin
                // Deselected enable changes leave the converter running
                if (bfault) begin
                    pw_d = ccis_pkg::PW_OFF;
                end else if (sel && !sup_en) begin
                    pw_d = ccis_pkg::PW_OFF;
                end
            end
            ccis_pkg::PW_IDLE: begin
                if (sel || (det && !det_q)) begin
                    pw_d = ccis_pkg::PW_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_q <= ccis_pkg::PW_OFF;
        end else begin
            pw_q <= pw_d;
        end
    end

    // ****************************************
    // Host data and reset hold
    // ****************************************
    logic data_q;
    logic data_d;
    logic crst_q;
    logic crst_d;

    always_comb begin
        data_d = data_q;
        crst_d = crst_q;
        if (sel) begin
            data_d = pin_s[ccis_pkg::PIN_DATA];
            crst_d = pin_s[ccis_pkg::PIN_RST];
        end
        // Deselected: both keep the last sampled level
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= 1'b1;
            // Zero request keeps the card reset line at its idle high level
            crst_q <= 1'b0;
        end else begin
            data_q <= data_d;
            crst_q <= crst_d;
        end
    end

    // ****************************************
    // Card clock divider
    // ****************************************
    logic [7:0] div_q;
    logic [7:0] div_d;
    logic       cclk_q;
    logic       cclk_d;

    always_comb begin
        div_d  = div_q;
        cclk_d = cclk_q;
        if (pw_q == ccis_pkg::PW_IDLE) begin
            div_d  = '0;
            cclk_d = 1'b0;
        end else if (!ctrl_q[ccis_pkg::CTRL_CLK_RUN]) begin
            div_d  = '0;
            cclk_d = ctrl_q[ccis_pkg::CTRL_STOP_LVL];
        end else if (div_q == 8'(CLK_DIV - 1)) begin
            div_d  = '0;
            cclk_d = ~cclk_q;
        end else begin
            div_d = div_q + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q  <= 8'h00;
            cclk_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            cclk_q <= cclk_d;
        end
    end

    // ****************************************
    // Alert, events and APB registers
    // ****************************************
    logic                         alert_q;
    logic                         alert_d;
    logic                         src_card_q;
    logic                         src_card_d;
    logic [ccis_pkg::EV_W-1:0]    ev_q;
    logic [ccis_pkg::EV_W-1:0]    ev_d;
    logic [ccis_pkg::EV_W-1:0]    ev_set;
    logic [ccis_pkg::EV_W-1:0]    mask_q;
    logic [ccis_pkg::EV_W-1:0]    mask_d;
    logic [ccis_pkg::CTRL_W-1:0]  ctrl_d;
    logic [ccis_pkg::ST_W-1:0]    state_v;
    logic                         monitor_on;
    logic                         acc;
    logic                         wr;
    logic                         rd;
    logic                         hit;
    logic [31:0]                  rdata;
    logic                         pready_d;
    logic [31:0]                  prdata_d;
    logic                         pslverr_d;
    logic                         stat_d;

    function automatic logic map_hit(input logic [7:0] a);
        map_hit = (a == ccis_pkg::CTRL_OFS) || (a == ccis_pkg::EVENT_OFS) ||
                  (a == ccis_pkg::MASK_OFS) || (a == ccis_pkg::STATE_OFS);
    endfunction

    always_comb begin
        // Supply sensing sleeps in idle, battery sensing never does
        monitor_on = (pw_q != ccis_pkg::PW_IDLE);
        ev_set = '0;
        ev_set[ccis_pkg::EV_CARD]     = card_evt;
        ev_set[ccis_pkg::EV_OVERLOAD] = ovld_evt & monitor_on;
        ev_set[ccis_pkg::EV_SUPPLY]   = sfault & ~sfault_q & monitor_on;
        ev_set[ccis_pkg::EV_BATTERY]  = bfault & ~bfault_q;

        // Alert sets win over a clear in the same cycle
        alert_d = alert_q;
        if (alert_clr) begin
            alert_d = 1'b0;
        end
        if (card_evt || ev_set[ccis_pkg::EV_OVERLOAD]) begin
            alert_d = 1'b1;
        end
        src_card_d = src_card_q;
        if (card_evt) begin
            src_card_d = 1'b1;
        end else if (ev_set[ccis_pkg::EV_OVERLOAD]) begin
            src_card_d = 1'b0;
        end

        // Status pin: event source first, then general health
        if (alert_q && src_card_q) begin
            stat_d = det;
        end else if (alert_q) begin
            stat_d = ~ovld;
        end else begin
            stat_d = ~(sfault | bfault) & ~ovld;
        end

        state_v = '0;
        state_v[ccis_pkg::ST_CARD]   = det;
        state_v[ccis_pkg::ST_SUPPLY] = (pw_q == ccis_pkg::PW_ON);
        state_v[ccis_pkg::ST_IDLE]   = (pw_q == ccis_pkg::PW_IDLE);
        state_v[ccis_pkg::ST_SEL]    = sel;
        state_v[ccis_pkg::ST_SFAULT] = sfault;
        state_v[ccis_pkg::ST_BFAULT] = bfault;
        state_v[ccis_pkg::ST_ALERT]  = alert_q;

        acc = psel & penable;
        hit = map_hit(paddr);
        wr  = acc & pready & pwrite & hit;
        rd  = acc & ~pready & ~pwrite;

        rdata = 32'h0000_0000;
        unique case (paddr)
            ccis_pkg::CTRL_OFS:  rdata[ccis_pkg::CTRL_W-1:0] = ctrl_q;
            ccis_pkg::EVENT_OFS: rdata[ccis_pkg::EV_W-1:0]   = ev_q;
            ccis_pkg::MASK_OFS:  rdata[ccis_pkg::EV_W-1:0]   = mask_q;
            ccis_pkg::STATE_OFS: rdata[ccis_pkg::ST_W-1:0]   = state_v;
            default:             rdata = 32'h0000_0000;
        endcase

        ctrl_d = ctrl_q;
        mask_d = mask_q;
        ev_d   = ev_q;
        if (wr && paddr == ccis_pkg::CTRL_OFS) begin
            ctrl_d = pwdata[ccis_pkg::CTRL_W-1:0];
        end
        if (wr && paddr == ccis_pkg::MASK_OFS) begin
            mask_d = pwdata[ccis_pkg::EV_W-1:0];
        end
        if (wr && paddr == ccis_pkg::EVENT_OFS) begin
            ev_d = ev_q & ~pwdata[ccis_pkg::EV_W-1:0];
        end
        ev_d = ev_d | ev_set;

        // One wait state: answer on the second access cycle
        pready_d  = acc & ~pready;
        prdata_d  = rd ? rdata : prdata;
        pslverr_d = acc & ~pready & ~hit;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alert_q    <= 1'b0;
            src_card_q <= 1'b0;
            ctrl_q     <= ccis_pkg::CTRL_RST;
            mask_q     <= ccis_pkg::MASK_RST;
            ev_q       <= ccis_pkg::EVENT_RST;
            pready     <= 1'b0;
            prdata     <= 32'h0000_0000;
            pslverr    <= 1'b0;
        end else begin
            alert_q    <= alert_d;
            src_card_q <= src_card_d;
            ctrl_q     <= ctrl_d;
            mask_q     <= mask_d;
            ev_q       <= ev_d;
            pready     <= pready_d;
            prdata     <= prdata_d;
            pslverr    <= pslverr_d;
        end
    end

    // ****************************************
    // Output registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_alert_n       <= 1'b1;
            status_out         <= 1'b1;
            card_supply        <= 1'b0;
            card_clock_out     <= 1'b0;
            card_data_line     <= 1'b1;
            card_reset_line    <= 1'b1;
            host_inputs_active <= 1'b0;
            low_power_idle     <= 1'b0;
            irq                <= 1'b0;
        end else begin
            // Alert drives its own pin and picks the source of the status pin
            host_alert_n       <= ~alert_d;
            status_out         <= stat_d;
            card_supply        <= (pw_d == ccis_pkg::PW_ON);
            card_clock_out     <= cclk_d;
            card_data_line     <= data_d;
            card_reset_line    <= ~crst_d;
            host_inputs_active <= sel;
            low_power_idle     <= (pw_d == ccis_pkg::PW_IDLE);
            irq                <= |(ev_d & mask_d);
        end
    end

endmodule

// file: testbench/ccis_host.sv
// Host controller model driving the coupler's select and control pins
`timescale 1ns/100ps
module ccis_host (
    // Clock
    input  wire logic pclk,
    // Host pins
    output logic      unit_select_n,
    output logic      supply_enable,
    output logic      host_data_in,
    output logic      host_reset_n
);
    // Select, data and reset parked high, enable low, so no current flows in the pull-ups
    initial begin
        unit_select_n = 1'b1;
        supply_enable = 1'b0;
        host_data_in  = 1'b1;
        host_reset_n  = 1'b1;
    end
    task automatic sel(input logic v);
        @(posedge pclk);
        unit_select_n <= v;
    endtask
    task automatic pwr(input logic v);
        @(posedge pclk);
        supply_enable <= v;
    endtask
    task automatic data(input logic d, input logic r);
        @(posedge pclk);
        host_data_in <= d;
        host_reset_n <= r;
    endtask
    // Converter off and data high before select goes high
    task automatic park();
        @(posedge pclk);
        supply_enable <= 1'b0;
        host_data_in  <= 1'b1;
        @(posedge pclk);
        unit_select_n <= 1'b1;
    endtask
endmodule

// file: testbench/ccis_top_chk.sv
// Assertion checker for the card coupler alert and select block
`timescale 1ns/100ps
module ccis_top_chk #(
    parameter int CLK_DIV = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Host and card pins
    input wire logic unit_select_n,
    input wire logic supply_enable,
    input wire logic card_detect_input,
    input wire logic supply_overload,
    input wire logic battery_over_v,
    input wire logic battery_under_v,
    input wire logic host_alert_n,
    input wire logic status_out,
    input wire logic card_supply,
    input wire logic card_data_line,
    input wire logic card_reset_line,
    input wire logic host_inputs_active,
    input wire logic low_power_idle
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ****************************************
    // Age of the last alert clearing cause
    // ****************************************
    logic       usn_q, usn_d;
    logic       sen_q, sen_d;
    logic [2:0] age_q, age_d;
    logic       cause;

    always_comb begin
        cause = (unit_select_n && !usn_q) || (supply_enable && !sen_q && !unit_select_n);
        usn_d = unit_select_n;
        sen_d = supply_enable;
        age_d = cause ? 3'h0 : ((age_q == 3'h7) ? 3'h7 : age_q + 3'h1);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usn_q <= 1'b1;
            sen_q <= 1'b0;
            age_q <= 3'h7;
        end else begin
            usn_q <= usn_d;
            sen_q <= sen_d;
            age_q <= age_d;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_alert_card_set: assert property (
        $changed(card_detect_input) |-> ##[3:5] !host_alert_n)
        else $error("alert missing after card change");
    a_status_card: assert property (
        $changed(card_detect_input) && !supply_overload
        |-> ##[3:5] (status_out == card_detect_input))
        else $error("status does not show card presence");
    a_ovld_alert: assert property (
        $rose(supply_overload) |-> ##[3:5] (!host_alert_n && !status_out))
        else $error("overload not reported");
    a_alert_release: assert property (
        $rose(host_alert_n) |-> age_q <= 3'h5)
        else $error("alert released without a clearing cause");
    a_sel_inputs: assert property (
        !unit_select_n [*5] |-> host_inputs_active)
        else $error("inputs inactive while selected");
    a_desel_inputs: assert property (
        unit_select_n [*5] |-> !host_inputs_active)
        else $error("inputs active while deselected");
    a_desel_hold: assert property (
        unit_select_n [*5] |=> $stable(card_data_line) && $stable(card_reset_line))
        else $error("card lines moved while deselected");
    a_supply_keep: assert property (
        (unit_select_n && !battery_over_v && !battery_under_v) [*8] ##0 card_supply
        |=> card_supply)
        else $error("card supply dropped while deselected");
    a_idle_exit: assert property (
        $fell(unit_select_n) || $rose(card_detect_input) |-> ##[1:5] !low_power_idle)
        else $error("idle state not left");
    a_pready_wait: assert property (
        psel && $rose(penable) |-> !pready ##1 pready)
        else $error("bus answer not after one wait state");
    a_pready_pulse: assert property (
        pready |=> !pready)
        else $error("bus answer longer than one cycle");
endmodule

bind ccis_top ccis_top_chk #(.CLK_DIV(CLK_DIV)) u_chk (.pclk, .presetn, .psel, .penable,
    .pready, .unit_select_n, .supply_enable, .card_detect_input, .supply_overload,
    .battery_over_v, .battery_under_v, .host_alert_n, .status_out, .card_supply,
    .card_data_line, .card_reset_line, .host_inputs_active, .low_power_idle);

// file: testbench/tb_card_coupler_irq_select.sv
// Self-checking testbench of the card coupler alert and select block
`timescale 1ns/100ps
module tb_card_coupler_irq_select;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        unit_select_n, supply_enable, host_data_in, host_reset_n;
    logic        card_detect_input, supply_overload, supply_over_v, supply_under_v;
    logic        battery_over_v, battery_under_v, host_alert_n, status_out, irq;
    logic        card_supply, card_clock_out, card_data_line, card_reset_line;
    logic        host_inputs_active, low_power_idle, er, c;
    int          n_mismatch, num_checks;

    ccis_top #(.CLK_DIV(2)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .unit_select_n, .supply_enable, .host_data_in,
        .host_reset_n, .host_alert_n, .status_out, .card_detect_input, .supply_overload,
        .supply_over_v, .supply_under_v, .battery_over_v, .battery_under_v, .card_supply,
        .card_clock_out, .card_data_line, .card_reset_line, .host_inputs_active,
        .low_power_idle, .irq);
    ccis_host u_host (.pclk, .unit_select_n, .supply_enable, .host_data_in, .host_reset_n);

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Ends on a falling edge so outputs are settled
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    // Answer is taken at the rising edge where pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            i++;
            if (i > 20) begin
                n_mismatch++;
                summarize();
            end
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {card_detect_input, supply_overload, supply_over_v, supply_under_v} = 4'h0;
        {battery_over_v, battery_under_v} = 2'h0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdc(ccis_pkg::CTRL_OFS, 32'(ccis_pkg::CTRL_RST));
        rdc(ccis_pkg::EVENT_OFS, 32'(ccis_pkg::EVENT_RST));
        rdc(ccis_pkg::MASK_OFS, 32'(ccis_pkg::MASK_RST));
        rdc(8'h10, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, ccis_pkg::MASK_OFS, 32'hF);
        rdc(ccis_pkg::MASK_OFS, 32'hF);
        u_host.sel(1'b0);
        wt(6);
        chk(host_inputs_active, 1'b1);
        apb(1'b0, ccis_pkg::STATE_OFS, 32'h0);
        chk(rd[ccis_pkg::ST_SEL], 1'b1);
        u_host.pwr(1'b1);
        wt(6);
        chk(card_supply, 1'b1);
        @(posedge pclk) card_detect_input <= 1'b1;
        wt(6);
        chk(host_alert_n, 1'b0);
        chk(status_out, 1'b1);
        chk(irq, 1'b1);
        rdc(ccis_pkg::EVENT_OFS, 32'h1);
        u_host.sel(1'b1);
        wt(6);
        chk(host_alert_n, 1'b1);
        chk(irq, 1'b1);
        chk(card_supply, 1'b1);
        u_host.sel(1'b0);
        apb(1'b1, ccis_pkg::EVENT_OFS, 32'hF);
        wt(2);
        chk(irq, 1'b0);
        @(posedge pclk) supply_overload <= 1'b1;
        wt(6);
        chk(host_alert_n, 1'b0);
        chk(status_out, 1'b0);
        rdc(ccis_pkg::EVENT_OFS, 32'h2);
        @(posedge pclk) supply_overload <= 1'b0;
        u_host.pwr(1'b0);
        wt(6);
        u_host.pwr(1'b1);
        wt(6);
        chk(host_alert_n, 1'b1);
        chk(status_out, 1'b1);
        apb(1'b1, ccis_pkg::EVENT_OFS, 32'hF);
        u_host.data(1'b0, 1'b0);
        wt(6);
        chk(card_data_line, 1'b0);
        chk(card_reset_line, 1'b0);
        u_host.sel(1'b1);
        wt(6);
        u_host.data(1'b1, 1'b1);
        u_host.pwr(1'b0);
        wt(6);
        chk(card_data_line, 1'b0);
        chk(card_reset_line, 1'b0);
        chk(card_supply, 1'b1);
        chk(host_inputs_active, 1'b0);
        c = card_clock_out;
        wt(2);
        chk(card_clock_out, !c);
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            supply_over_v   <= (k == 0);
            supply_under_v  <= (k == 1);
            battery_over_v  <= (k == 2);
            battery_under_v <= (k == 3);
            wt(6);
            rdc(ccis_pkg::EVENT_OFS, (k < 2) ? 32'h4 : 32'h8);
            if (k >= 2) chk(card_supply, 1'b0);
            @(posedge pclk);
            supply_over_v   <= 1'b0;
            supply_under_v  <= 1'b0;
            battery_over_v  <= 1'b0;
            battery_under_v <= 1'b0;
            wt(4);
            apb(1'b1, ccis_pkg::EVENT_OFS, 32'hF);
        end
        apb(1'b1, ccis_pkg::CTRL_OFS, 32'h5);
        @(posedge pclk) card_detect_input <= 1'b0;
        wt(8);
        chk(low_power_idle, 1'b1);
        @(posedge pclk) card_detect_input <= 1'b1;
        wt(6);
        chk(low_power_idle, 1'b0);
        chk(host_alert_n, 1'b0);
        @(posedge pclk) card_detect_input <= 1'b0;
        wt(8);
        chk(low_power_idle, 1'b1);
        u_host.sel(1'b0);
        wt(6);
        chk(low_power_idle, 1'b0);
        u_host.park();
        wt(6);
        chk(host_alert_n, 1'b1);
        summarize();
    end
endmodule
